// file: ics_bus_master.sv
// Purpose: bus master model for the two-wire control port
// Assumes: open-drain lines with pull-ups; the slave never stretches
// Notes:   q is a quarter bus period in system clocks
`timescale 1ns/1ns
`default_nettype none

module ics_bus_master (
	input  wire logic clock_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	int q = 13;

	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// =====================================================
	// bit, byte and condition tasks
	task automatic tick();
		repeat (q) @(negedge clock_i);
	endtask : tick

	// drive in low phase, sample at middle and end of high phase
	task automatic bit_cyc(input logic b, output logic s);
		logic s0;
		tick();
		sda_o = b;
		tick();
		scl_o = 1'b1;
		tick();
		s0 = sda_i;
		tick();
		s = s0 | sda_i;
		scl_o = 1'b0;
	endtask : bit_cyc

	task automatic start_c();
		tick();
		sda_o = 1'b1;
		tick();
		scl_o = 1'b1;
		tick();
		sda_o = 1'b0;
		tick();
		scl_o = 1'b0;
	endtask : start_c

	task automatic stop_c();
		tick();
		sda_o = 1'b0;
		tick();
		scl_o = 1'b1;
		tick();
		sda_o = 1'b1;
		tick();
	endtask : stop_c

	// msb first, then the acknowledge clock
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_cyc(d[i], s);
		bit_cyc(1'b1, ack);
	endtask : write_byte

	task automatic read_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_cyc(1'b1, d[i]);
		bit_cyc(nack, s);
	endtask : read_byte

endmodule : ics_bus_master

`default_nettype wire

// file: ics_i2c_control_slave.sv
// Purpose: two-wire control-port slave for configuration and coefficients
// Assumes: register owner supplies set length and read data per subaddress
// Notes:   runs on the system clock only; never drives the clock line
`timescale 1ns/1ns
`default_nettype none

module ics_i2c_control_slave
	import ics_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       resetn_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oen_o,
	input  wire logic       addr_select_or_phone_shutdown_pin_i,
	output logic            addr_select_or_phone_shutdown_pin_o,
	output logic            addr_select_or_phone_shutdown_pin_oen_o,
	input  wire logic       pin_output_enable_i,
	input  wire logic       phone_shutdown_i,
	output logic [7:0]      cur_subaddr_o,
	input  wire logic [5:0] set_len_i,
	output logic [5:0]      rd_idx_o,
	input  wire logic [7:0] rd_data_i,
	output logic            rd_strobe_o,
	output logic            reg_wr_valid_o,
	output logic [7:0]      reg_wr_addr_o,
	output logic [5:0]      reg_wr_idx_o,
	output logic [7:0]      reg_wr_data_o,
	output logic            reg_wr_last_o
);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	ics_state_type state_r;
	logic          scl_m_r, scl_s_r, scl_d_r;
	logic          sda_m_r, sda_s_r, sda_d_r;
	logic          pin_m_r, pin_s_r;
	logic [1:0]    strap_cnt_r;
	logic          strap_done_r;
	logic          strap_r;
	logic [3:0]    bit_cnt_r;
	logic [7:0]    shift_r;
	logic          rw_r;
	logic          mack_r;
	logic [7:0]    subaddr_r;
	logic [5:0]    widx_r;
	logic [5:0]    rbyte_r;
	logic [7:0]    tx_r;
	logic          sda_oen_r;
	logic          dump_act_r;
	logic [5:0]    dump_idx_r;
	logic [5:0]    dump_len_r;
	logic [7:0]    dump_addr_r;
	logic          dp_valid_r;
	logic [5:0]    dp_idx_r;
	logic          dp_last_r;
	logic          commit_r;

	ics_stage_if stg ();

	ics_stage_mem u_stage (
		.clock_i  (clock_i),
		.resetn_i (resetn_i),
		.st       (stg.store)
	);

	// =====================================================
	// pin synchronisers
	// three-cycle latency, far below fast-mode low time
	// only the system clock is used
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
			pin_m_r <= 1'b0;
			pin_s_r <= 1'b0;
		end
		else
		begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
			pin_m_r <= addr_select_or_phone_shutdown_pin_i;
			pin_s_r <= pin_m_r;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det, byte_end, addr_hit;
	logic [5:0] eff_len;
	logic [7:0] rd_byte;

	assign scl_rise  = scl_s_r & ~scl_d_r;
	assign scl_fall  = ~scl_s_r & scl_d_r;
	assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
	// eight bits then the acknowledge slot
	assign byte_end  = scl_fall && (bit_cnt_r == ICS_BYTE_BITS);
	assign addr_hit  = strap_done_r &&
		(shift_r[7:1] == (strap_r ? ICS_DEV_ADDR_HIGH : ICS_DEV_ADDR_LOW));
	// zero length treated as one byte
	assign eff_len   = (set_len_i == 6'h00) ? ICS_LEN_ONE : set_len_i;
	assign rd_byte   = (set_len_i == 6'h00) ? 8'h00 : rd_data_i;

	// =====================================================
	// strap capture and shutdown pin
	// sample strap after release, drive only when enabled
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			strap_cnt_r  <= 2'h0;
			strap_done_r <= 1'b0;
			strap_r      <= 1'b0;
			addr_select_or_phone_shutdown_pin_o   <= 1'b0;
			addr_select_or_phone_shutdown_pin_oen_o <= 1'b1;
		end
		else
		begin
			if (!strap_done_r)
			begin
				strap_cnt_r <= strap_cnt_r + 2'h1;
				if (strap_cnt_r == ICS_STRAP_WAIT)
				begin
					strap_done_r <= 1'b1;
					strap_r      <= pin_s_r;
				end
			end
			addr_select_or_phone_shutdown_pin_o   <= phone_shutdown_i;
			addr_select_or_phone_shutdown_pin_oen_o <= ~(strap_done_r & pin_output_enable_i);
		end
	end

	// =====================================================
	// bus state machine
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_r   <= ICS_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
			rw_r      <= 1'b0;
			mack_r    <= 1'b1;
		end
		else if (start_det)
		begin
			// start or repeated start reopens addressing
			state_r   <= ICS_ADDR;
			bit_cnt_r <= 4'h0;
		end
		else if (stop_det)
		begin
			state_r <= ICS_IDLE;
		end
		else
		begin
			// shift in on rising SCL, MSB first
			if (scl_rise && bit_cnt_r != ICS_BYTE_BITS)
			begin
				shift_r   <= {shift_r[6:0], sda_s_r};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
			case (state_r)
				ICS_ADDR:
				begin
					if (byte_end)
					begin
						// no match: stay off the bus
						state_r   <= addr_hit ? ICS_ADDR_ACK : ICS_IGNORE;
						rw_r      <= shift_r[0];
						bit_cnt_r <= 4'h0;
					end
				end
				ICS_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						state_r <= rw_r ? ICS_RDATA : ICS_SUB;
						// ack clock is not a data bit
						bit_cnt_r <= 4'h0;
					end
				end
				ICS_SUB:
				begin
					if (byte_end)
					begin
						state_r   <= ICS_SUB_ACK;
						bit_cnt_r <= 4'h0;
					end
				end
				ICS_SUB_ACK, ICS_WDATA_ACK:
				begin
					if (scl_fall)
					begin
						state_r <= ICS_WDATA;
						bit_cnt_r <= 4'h0;
					end
				end
				ICS_WDATA:
				begin
					if (byte_end)
					begin
						state_r   <= ICS_WDATA_ACK;
						bit_cnt_r <= 4'h0;
					end
				end
				ICS_RDATA:
				begin
					if (byte_end)
					begin
						state_r   <= ICS_RDATA_ACK;
						bit_cnt_r <= 4'h0;
					end
				end
				ICS_RDATA_ACK:
				begin
					if (scl_rise)
					begin
						mack_r <= sda_s_r;
					end
					if (scl_fall)
					begin
						state_r <= mack_r ? ICS_IGNORE : ICS_RDATA;
						bit_cnt_r <= 4'h0;
					end
				end
				default:
				begin
					state_r <= state_r;
				end
			endcase
		end
	end

	// =====================================================
	// subaddress and byte pointers
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			subaddr_r <= 8'h00;
			widx_r    <= 6'h00;
			rbyte_r   <= 6'h00;
			commit_r  <= 1'b0;
		end
		else
		begin
			commit_r <= 1'b0;
			if (start_det || stop_det)
			begin
				// a partial set is never committed
				widx_r <= 6'h00;
			end
			else if (state_r == ICS_SUB && byte_end)
			begin
				subaddr_r <= shift_r;
				widx_r    <= 6'h00;
				rbyte_r   <= 6'h00;
			end
			else if (state_r == ICS_WDATA && byte_end)
			begin
				// count bytes against the set length
				if (widx_r + ICS_LEN_ONE >= eff_len)
				begin
					commit_r  <= 1'b1;
					subaddr_r <= subaddr_r + 8'h01;
					widx_r    <= 6'h00;
				end
				else
				begin
					widx_r <= widx_r + ICS_LEN_ONE;
				end
			end
			else if (state_r == ICS_RDATA && byte_end)
			begin
				// prefetch pointer for the next byte
				if (rbyte_r + ICS_LEN_ONE >= eff_len)
				begin
					subaddr_r <= subaddr_r + 8'h01;
					rbyte_r   <= 6'h00;
				end
				else
				begin
					rbyte_r <= rbyte_r + ICS_LEN_ONE;
				end
			end
		end
	end

	assign stg.wr_en   = (state_r == ICS_WDATA) && byte_end;
	assign stg.wr_idx  = widx_r[ICS_STAGE_AW-1:0];
	assign stg.wr_data = shift_r;
	assign stg.rd_idx  = dump_idx_r[ICS_STAGE_AW-1:0];

	// =====================================================
	// SDA driver
	// only SDA is ever driven, never SCL
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sda_oen_r   <= 1'b1;
			tx_r        <= 8'h00;
			rd_strobe_o <= 1'b0;
		end
		else
		begin
			rd_strobe_o <= 1'b0;
			if (start_det || stop_det)
			begin
				sda_oen_r <= 1'b1;
			end
			else if (scl_fall)
			begin
				// all changes right after SCL falls
				case (state_r)
					ICS_ADDR, ICS_SUB, ICS_WDATA:
					begin
						if (byte_end)
						begin
							sda_oen_r <= ~((state_r != ICS_ADDR) || addr_hit);
						end
					end
					ICS_ADDR_ACK, ICS_RDATA_ACK:
					begin
						// load first or next read byte
						if ((state_r == ICS_ADDR_ACK && rw_r) ||
							(state_r == ICS_RDATA_ACK && !mack_r))
						begin
							tx_r        <= rd_byte;
							sda_oen_r   <= rd_byte[7];
							rd_strobe_o <= 1'b1;
						end
						else
						begin
							sda_oen_r <= 1'b1;
						end
					end
					ICS_SUB_ACK, ICS_WDATA_ACK:
					begin
						sda_oen_r <= 1'b1;
					end
					ICS_RDATA:
					begin
						if (byte_end)
						begin
							sda_oen_r <= 1'b1;
						end
						else
						begin
							tx_r      <= {tx_r[6:0], 1'b0};
							sda_oen_r <= tx_r[6];
						end
					end
					default:
					begin
						sda_oen_r <= 1'b1;
					end
				endcase
			end
		end
	end

	assign sda_o     = 1'b0;
	assign sda_oen_o = sda_oen_r;

	// =====================================================
	// commit drain to register owner
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			dump_act_r     <= 1'b0;
			dump_idx_r     <= 6'h00;
			dump_len_r     <= 6'h00;
			dump_addr_r    <= 8'h00;
			dp_valid_r     <= 1'b0;
			dp_idx_r       <= 6'h00;
			dp_last_r      <= 1'b0;
			reg_wr_valid_o <= 1'b0;
			reg_wr_addr_o  <= 8'h00;
			reg_wr_idx_o   <= 6'h00;
			reg_wr_data_o  <= 8'h00;
			reg_wr_last_o  <= 1'b0;
		end
		else
		begin
			if (commit_r)
			begin
				dump_act_r  <= 1'b1;
				dump_idx_r  <= 6'h00;
				dump_len_r  <= eff_len;
				dump_addr_r <= subaddr_r - 8'h01;
			end
			else if (dump_act_r)
			begin
				dump_idx_r <= dump_idx_r + ICS_LEN_ONE;
				if (dump_idx_r + ICS_LEN_ONE >= dump_len_r)
				begin
					dump_act_r <= 1'b0;
				end
			end
			dp_valid_r     <= dump_act_r;
			dp_idx_r       <= dump_idx_r;
			dp_last_r      <= dump_act_r && (dump_idx_r + ICS_LEN_ONE >= dump_len_r);
			reg_wr_valid_o <= dp_valid_r;
			reg_wr_addr_o  <= dump_addr_r;
			reg_wr_idx_o   <= dp_idx_r;
			reg_wr_data_o  <= stg.rd_data;
			reg_wr_last_o  <= dp_last_r;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cur_subaddr_o <= 8'h00;
			rd_idx_o      <= 6'h00;
		end
		else
		begin
			cur_subaddr_o <= subaddr_r;
			rd_idx_o      <= rbyte_r;
		end
	end

	// =====================================================
	// checks
	a_start_opens: assert property (start_det |=> state_r == ICS_ADDR)
		else $error("start not taken");
	a_stop_closes: assert property (stop_det && !start_det |=> state_r == ICS_IDLE)
		else $error("stop not taken");
	a_sda_scl_low: assert property ($changed(sda_oen_r) |-> !scl_d_r)
		else $error("sda changed with scl high");
	a_ack_held: assert property (state_r == ICS_SUB_ACK |-> !sda_oen_r)
		else $error("ack not held low");
	a_addr_match: assert property ($rose(state_r == ICS_ADDR_ACK) |-> $past(addr_hit))
		else $error("ack to wrong address");
	a_nomatch_free: assert property (state_r == ICS_IGNORE |-> sda_oen_r)
		else $error("sda driven while ignoring");
	a_strap_input: assert property (!strap_done_r |=> addr_select_or_phone_shutdown_pin_oen_o)
		else $error("strap pin driven early");
	a_strap_stable: assert property (strap_done_r |=> $stable(strap_r))
		else $error("strap changed");
	a_full_commit: assert property (commit_r |-> $past(widx_r) + ICS_LEN_ONE >= eff_len)
		else $error("short set committed");
	a_drain_bytes: assert property (commit_r |=> dump_act_r ##2 reg_wr_valid_o)
		else $error("commit not drained");

endmodule : ics_i2c_control_slave

`default_nettype wire

// file: ics_pkg.sv
// Purpose: shared constants and types of the two-wire control slave
// Assumes: 20 MHz system clock, bus pins sampled through synchronisers
// Notes:   staging depth covers the widest data set of one subaddress
package ics_pkg;

	// =====================================================
	// device addresses (7-bit, selected by the strap pin)
	localparam logic [6:0] ICS_DEV_ADDR_LOW  = 7'h2A;
	localparam logic [6:0] ICS_DEV_ADDR_HIGH = 7'h2B;

	// =====================================================
	// byte framing
	localparam logic [3:0] ICS_BYTE_BITS = 4'h8;
	localparam logic [5:0] ICS_LEN_ONE   = 6'h01;

	// =====================================================
	// staging memory
	localparam int         ICS_STAGE_DEPTH = 32;
	localparam int         ICS_STAGE_AW    = 5;

	// =====================================================
	// strap capture: edges after reset release before sampling
	localparam logic [1:0] ICS_STRAP_WAIT = 2'h3;

	// =====================================================
	// bus states
	typedef enum logic [9:0] {
		ICS_IDLE      = 10'h001,
		ICS_ADDR      = 10'h002,
		ICS_ADDR_ACK  = 10'h004,
		ICS_SUB       = 10'h008,
		ICS_SUB_ACK   = 10'h010,
		ICS_WDATA     = 10'h020,
		ICS_WDATA_ACK = 10'h040,
		ICS_RDATA     = 10'h080,
		ICS_RDATA_ACK = 10'h100,
		ICS_IGNORE    = 10'h200
	} ics_state_type;

endpackage : ics_pkg

// file: ics_stage_if.sv
// Purpose: carrier between the bus engine and its staging memory
// Assumes: one clock domain
// Notes:   read data appear one edge after the read index
`timescale 1ns/1ns
`default_nettype none

interface ics_stage_if;
	import ics_pkg::*;

	logic                    wr_en;
	logic [ICS_STAGE_AW-1:0] wr_idx;
	logic [7:0]              wr_data;
	logic [ICS_STAGE_AW-1:0] rd_idx;
	logic [7:0]              rd_data;

	modport engine (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport store  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);

endinterface : ics_stage_if

`default_nettype wire

// file: ics_stage_mem.sv
// Purpose: staging store for the bytes of one incomplete data set
// Assumes: written by the bus engine, drained after the set completes
// Notes:   registered read port
`timescale 1ns/1ns
`default_nettype none

module ics_stage_mem
	import ics_pkg::*;
(
	input  wire logic  clock_i,
	input  wire logic  resetn_i,
	ics_stage_if.store st
);

	// =====================================================
	// storage array
	logic [7:0] mem_r [ICS_STAGE_DEPTH];
	logic [7:0] rd_r;

	always_ff @(posedge clock_i)
	begin
		if (st.wr_en)
		begin
			mem_r[st.wr_idx] <= st.wr_data;
		end
	end

	// =====================================================
	// registered read
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rd_r <= 8'h00;
		end
		else
		begin
			rd_r <= mem_r[st.rd_idx];
		end
	end

	assign st.rd_data = rd_r;

endmodule : ics_stage_mem

`default_nettype wire

// file: tb_i2c_control_slave.sv
// Purpose: self-checking bench of the two-wire control slave
// Assumes: bench models the register owner and the strap pull
// Notes:   write rows in a table, awkward cases after the loop
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module tb_i2c_control_slave
	import ics_pkg::*;
;
	typedef struct {logic [7:0] sub; int nb; int ncom;} ics_row_type;

	logic        clock_i, resetn_i, strap, pin_en, hp_sd, m_scl, m_sda;
	logic        sda_o, sda_oen, sel_out, sel_oen, rd_stb, wr_v, wr_last;
	logic [5:0]  set_len, rd_idx, wr_idx;
	logic [7:0]  rd_data, cur_sub, wr_addr, wr_data;
	logic        sda_line, sel_pin;
	logic        ak;
	int          n_stb = 0;
	logic [22:0] com_q[$];
	int          n_mismatch = 0;
	int          compares = 0;
	ics_row_type rows[7] = '{'{8'h01, 1, 1}, '{8'h02, 3, 3}, '{8'h20, 4, 4},
		'{8'h20, 6, 4}, '{8'h21, 3, 0}, '{8'h30, 20, 20}, '{8'h1F, 5, 5}};

	assign sda_line = m_sda & (sda_oen | sda_o);
	assign sel_pin  = sel_oen ? strap : sel_out;

	ics_bus_master u_master (.clock_i(clock_i), .sda_i(sda_line), .scl_o(m_scl), .sda_o(m_sda));

	ics_i2c_control_slave u_dut (
		.clock_i(clock_i), .resetn_i(resetn_i), .scl_i(m_scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oen_o(sda_oen), .addr_select_or_phone_shutdown_pin_i(sel_pin),
		.addr_select_or_phone_shutdown_pin_o(sel_out),
		.addr_select_or_phone_shutdown_pin_oen_o(sel_oen), .pin_output_enable_i(pin_en),
		.phone_shutdown_i(hp_sd), .cur_subaddr_o(cur_sub), .set_len_i(set_len),
		.rd_idx_o(rd_idx), .rd_data_i(rd_data), .rd_strobe_o(rd_stb), .reg_wr_valid_o(wr_v),
		.reg_wr_addr_o(wr_addr), .reg_wr_idx_o(wr_idx), .reg_wr_data_o(wr_data),
		.reg_wr_last_o(wr_last));

	// =====================================================
	// clock, register owner model and commit monitor
	initial
	begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	function automatic int lenf(input logic [7:0] s);
		return (s >= 8'h30) ? 20 : ((s >= 8'h20) ? 4 : ((s == 8'h1E) ? 0 : 1));
	endfunction : lenf

	function automatic logic [7:0] dat(input logic [7:0] s, input int k);
		return 8'(s + 7 * k + 1);
	endfunction : dat

	always @(negedge clock_i)
	begin
		set_len <= 6'(lenf(cur_sub));
		rd_data <= cur_sub + {rd_idx, 2'b00};
		if (wr_v === 1'b1)
			com_q.push_back({wr_addr, wr_idx, wr_data, wr_last});
		if (rd_stb === 1'b1)
			n_stb++;
	end

	// =====================================================
	// tasks
	task automatic end_of_test();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task automatic reset_dut(input logic st);
		@(negedge clock_i);
		strap = st;
		resetn_i = 1'b0;
		repeat (20) @(negedge clock_i);
		`CHK("oen in reset", 1'b1, sda_oen)
		`CHK("pin oen in reset", 1'b1, sel_oen)
		resetn_i = 1'b1;
		repeat (10) @(negedge clock_i);
	endtask : reset_dut

	task automatic send_head(input logic [6:0] ad, input logic rw, input logic ex);
		logic a;
		u_master.start_c();
		u_master.write_byte({ad, rw}, a);
		`CHK("addr ack", ex, a)
	endtask : send_head

	task automatic wr_xfer(input logic [7:0] sub, input int nb, input int ncom);
		logic        a;
		logic [7:0]  p;
		logic [22:0] e[$];
		int          i;
		com_q.delete();
		send_head(ICS_DEV_ADDR_LOW, 1'b0, 1'b0);
		u_master.write_byte(sub, a);
		`CHK("sub ack", 1'b0, a)
		for (int k = 0; k < nb; k++)
		begin
			u_master.write_byte(dat(sub, k), a);
			`CHK("data ack", 1'b0, a)
		end
		u_master.stop_c();
		repeat (100) @(negedge clock_i);
		`CHK("commit count", ncom, com_q.size())
		p = sub;
		i = 0;
		for (int k = 0; k < nb; k++)
		begin
			i++;
			if (i == lenf(p))
			begin
				for (int j = 0; j < i; j++)
					e.push_back({p, 6'(j), dat(sub, k - i + 1 + j), j == i - 1});
				p++;
				i = 0;
			end
		end
		for (int k = 0; k < e.size() && k < com_q.size(); k++)
			`CHK("commit", e[k], com_q[k])
	endtask : wr_xfer

	task automatic rd_xfer(input logic [7:0] sub, input int n);
		logic       a;
		logic [7:0] d, p;
		int         i;
		n_stb = 0;
		send_head(ICS_DEV_ADDR_LOW, 1'b0, 1'b0);
		u_master.write_byte(sub, a);
		send_head(ICS_DEV_ADDR_LOW, 1'b1, 1'b0);
		p = sub;
		i = 0;
		for (int k = 0; k < n; k++)
		begin
			// not-acknowledge on the last byte only
			u_master.read_byte(k == n - 1, d);
			`CHK("read byte", (lenf(p) == 0) ? 8'h00 : 8'(p + 4 * i), d)
			i++;
			if (i >= lenf(p))
			begin
				p++;
				i = 0;
			end
		end
		u_master.stop_c();
		`CHK("read strobes", n, n_stb)
	endtask : rd_xfer

	// =====================================================
	// main sequence
	initial
	begin
		resetn_i = 1'b0;
		strap = 1'b0;
		pin_en = 1'b0;
		hp_sd = 1'b0;
		set_len = 6'h01;
		rd_data = 8'h00;
		reset_dut(1'b0);
		foreach (rows[r])
			wr_xfer(rows[r].sub, rows[r].nb, rows[r].ncom);
		u_master.q = 50;
		wr_xfer(8'h05, 2, 2);
		u_master.q = 13;
		rd_xfer(8'h05, 3);
		rd_xfer(8'h1F, 5);
		rd_xfer(8'h1E, 2);
		// set cut short by a repeated start is dropped
		com_q.delete();
		send_head(ICS_DEV_ADDR_LOW, 1'b0, 1'b0);
		u_master.write_byte(8'h21, ak);
		u_master.write_byte(8'hAA, ak);
		u_master.write_byte(8'hBB, ak);
		`CHK("cut ack", 1'b0, ak)
		`CHK("cut commits", 0, com_q.size())
		wr_xfer(8'h01, 1, 1);
		com_q.delete();
		send_head(7'h2C, 1'b0, 1'b1);
		u_master.write_byte(8'h01, ak);
		`CHK("ignored ack", 1'b1, ak)
		u_master.stop_c();
		repeat (50) @(negedge clock_i);
		`CHK("ignored commits", 0, com_q.size())
		pin_en = 1'b1;
		hp_sd = 1'b1;
		repeat (4) @(negedge clock_i);
		`CHK("pin oen", 1'b0, sel_oen)
		`CHK("pin out", 1'b1, sel_out)
		wr_xfer(8'h03, 1, 1);
		pin_en = 1'b0;
		repeat (4) @(negedge clock_i);
		`CHK("pin oen off", 1'b1, sel_oen)
		reset_dut(1'b1);
		send_head(ICS_DEV_ADDR_LOW, 1'b0, 1'b1);
		u_master.stop_c();
		send_head(ICS_DEV_ADDR_HIGH, 1'b0, 1'b0);
		u_master.stop_c();
		end_of_test();
	end

	initial
	begin
		repeat (95000) @(posedge clock_i);
		n_mismatch++;
		end_of_test();
	end

endmodule : tb_i2c_control_slave

`default_nettype wire
